// ### rtl/schc_consts.svh
// Purpose: constants of the smart card host control block
// Assumes: 25 MHz system clock
// Notes: timing figures kept in their own unit, counts derived from them
// Overview of operation
// - select high: controls act live; select low: last values held and used
// - deselected: host data lines weakly pulled up, no data, status floats
// - mode input low selects asynchronous, high selects synchronous cards
// - falling power request starts activation only when a card is present
// - voltage input picks 5.0 or 3.0 volts; sequencer switches converter
// - once enabled by the sequencer, card reset follows host reset input
// - divider inputs: 00 half, 01 full, 10 quarter, 11 half rate
// - divide-by-one follows oscillator waveform, others near 50% duty
// - outside a session status shows card presence; a latched fault keeps it low until the request rises
// - in session, removal or any fault drops status and deactivates
// - synchronous mode: card clock from strobe; async mode ignores strobe
// - buffer output copies the oscillator input, held low while asleep
// - over-current starts deactivation and flags a fault on status
// - either supply supervisor fault triggers deactivation
// - host supply supervisor restarts the wake-up wait and forces deactivation
// - sleep input stops oscillators, card interface and converter
// - presence detection works asleep; insertion raises status
// - normal operation resumes 10 ms after sleep release; status then rises
// - power request falls asleep or during wake-up are ignored
// - async mode holds card reset low 42000 card clocks after clock start
// - deactivation order: reset, clock, data lines, then supply off
`ifndef SCHC_CONSTS_SVH
`define SCHC_CONSTS_SVH
`define SCHC_CLK_HZ 25000000
`define SCHC_WAKE_MS 10
`define SCHC_WAKE_CYCLES (`SCHC_WAKE_MS * (`SCHC_CLK_HZ / 1000))
`define SCHC_STEP_NS 1000
`define SCHC_STEP_CYCLES ((`SCHC_STEP_NS * (`SCHC_CLK_HZ / 1000000) + 999) / 1000)
`define SCHC_RST_HOLD_CLKS 42000
`define SCHC_DIV_HALF_A 2'h0
`define SCHC_DIV_FULL 2'h1
`define SCHC_DIV_QUARTER 2'h2
`endif

// ### rtl/schc_pkg.sv
// Purpose: types of the smart card host control block
// Assumes: nothing
// Notes: control fields grouped so they can be held as one word
package schc_pkg;
    typedef struct packed {
        logic power_request_n;
        logic voltage_select;
        logic host_reset;
        logic sync_mode;
        logic div_hi;
        logic div_lo;
        logic sleep_request;
    } schc_ctrl_type;

    typedef struct packed {
        schc_ctrl_type ctrl;
        logic unit_select;
        logic presence;
        logic over_current;
        logic over_temp;
        logic vcc_fault;
        logic vdd_fault;
        logic osc;
        logic strobe;
        logic [2:0] host_data;
        logic [2:0] card_data;
    } schc_pins_type;

    typedef enum logic [3:0] {
        SEQ_OFF, SEQ_ACT_VCC, SEQ_ACT_IO, SEQ_ACT_CLK, SEQ_ON,
        SEQ_DEACT_RST, SEQ_DEACT_CLK, SEQ_DEACT_IO, SEQ_DEACT_VCC
    } schc_seq_type;
endpackage

// ### rtl/schc_host_control.sv
// Purpose: host side control, sequencer and card clock of a card interface
// Assumes: every pin input except i_clk and i_rst_b is asynchronous to i_clk and is synchronised
// Notes: card clock edges are quantised to the system clock
`include "schc_consts.svh"
module schc_host_control
    import schc_pkg::*;
#(
    parameter int WAKE_CYCLES = `SCHC_WAKE_CYCLES,
    parameter int STEP_CYCLES = `SCHC_STEP_CYCLES,
    parameter int RST_HOLD_CLKS = `SCHC_RST_HOLD_CLKS
) (
    input wire logic i_clk, // system clock
    input wire logic i_rst_b, // async reset, active low
    input wire logic i_unit_select, // chip select, high = live
    input wire logic i_card_power_request_n, // activation request, low
    input wire logic i_card_voltage_select, // 1 = 5.0 V, 0 = 3.0 V
    input wire logic i_host_reset_in, // reset level for the card
    input wire logic i_sync_mode_select, // 1 = synchronous cards
    input wire logic i_div_select_hi, // divider select high bit
    input wire logic i_div_select_lo, // divider select low bit
    input wire logic i_sleep_request, // power-down, active high
    input wire logic i_presence_detect, // card present, high
    input wire logic i_over_current, // card supply over-current
    input wire logic i_over_temp, // die over-temperature
    input wire logic i_vcc_fault, // card supply supervisor fault
    input wire logic i_vdd_fault, // host supply supervisor fault
    input wire logic i_osc_input, // oscillator input
    input wire logic i_strobe, // synchronous card clock source
    input wire logic [2:0] i_host_data, // host data, aux1, aux2 levels
    output logic [2:0] o_host_data, // host line drive value
    output logic [2:0] o_host_data_oe, // host line drive enable
    output logic o_host_weak_pullup, // weak pull-up on host lines
    input wire logic [2:0] i_card_data, // card data, aux1, aux2 levels
    output logic [2:0] o_card_data, // card line drive value
    output logic [2:0] o_card_data_oe, // card line drive enable
    output logic o_status, // status interrupt value
    output logic o_status_oe, // status interrupt drive enable
    output logic o_card_clk, // card clock
    output logic o_card_rst, // card reset
    output logic o_conv_enable, // card supply converter on
    output logic o_conv_5v_select, // converter set point 5.0 V
    output logic o_sleep_state, // lowest power state active
    output logic o_osc_buffer_out // buffered oscillator copy
);
    localparam int WW = $clog2(WAKE_CYCLES + 1);
    localparam int SW = $clog2(STEP_CYCLES + 1);
    localparam int RW = $clog2(RST_HOLD_CLKS + 1);

    generate
        if (WAKE_CYCLES < 1 || STEP_CYCLES < 1 || RST_HOLD_CLKS < 1) begin
            $error("schc_host_control: counts must be at least one");
        end
    endgenerate

    schc_pins_type pins;
    schc_pins_type sync1_reg, sync2_reg;
    schc_ctrl_type held_reg, held_next;

    // gather the pins so one pair of flops synchronises them all
    always_comb begin
        pins.ctrl.power_request_n = i_card_power_request_n;
        pins.ctrl.voltage_select = i_card_voltage_select;
        pins.ctrl.host_reset = i_host_reset_in;
        pins.ctrl.sync_mode = i_sync_mode_select;
        pins.ctrl.div_hi = i_div_select_hi;
        pins.ctrl.div_lo = i_div_select_lo;
        pins.ctrl.sleep_request = i_sleep_request;
        pins.unit_select = i_unit_select;
        pins.presence = i_presence_detect;
        pins.over_current = i_over_current;
        pins.over_temp = i_over_temp;
        pins.vcc_fault = i_vcc_fault;
        pins.vdd_fault = i_vdd_fault;
        pins.osc = i_osc_input;
        pins.strobe = i_strobe;
        pins.host_data = i_host_data;
        pins.card_data = i_card_data;
    end

    // reset levels: request idle high, lines idle high, rest low
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync1_reg.ctrl.power_request_n <= 1'b1;
            sync2_reg.ctrl.power_request_n <= 1'b1;
            sync1_reg.host_data <= 3'h7;
            sync2_reg.host_data <= 3'h7;
            sync1_reg.card_data <= 3'h7;
            sync2_reg.card_data <= 3'h7;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
        end
    end

    // held controls track while selected, freeze once deselected
    always_comb begin
        held_next = sync2_reg.unit_select ? sync2_reg.ctrl : held_reg;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            held_reg <= '0;
            held_reg.power_request_n <= 1'b1;
        end else begin
            held_reg <= held_next;
        end
    end

    // sleep state and wake-up stabilisation timer
    logic sleep_reg, sleep_next;
    logic awake_reg, awake_next;
    logic [WW-1:0] wake_cnt_reg, wake_cnt_next;

    always_comb begin
        sleep_next = held_reg.sleep_request;
        awake_next = awake_reg;
        wake_cnt_next = wake_cnt_reg;
        if (held_reg.sleep_request || sync2_reg.vdd_fault) begin
            // supply fault restarts the same wait as power-on
            awake_next = 1'b0;
            wake_cnt_next = '0;
        end else if (!awake_reg) begin
            if (wake_cnt_reg == WW'(WAKE_CYCLES - 1)) begin
                awake_next = 1'b1;
            end else begin
                wake_cnt_next = wake_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sleep_reg <= 1'b0;
            awake_reg <= 1'b0;
            wake_cnt_reg <= '0;
        end else begin
            sleep_reg <= sleep_next;
            awake_reg <= awake_next;
            wake_cnt_reg <= wake_cnt_next;
        end
    end

    // activation and deactivation sequencer
    schc_seq_type seq_reg, seq_next;
    logic [SW-1:0] step_reg, step_next;
    logic [RW-1:0] rst_cnt_reg, rst_cnt_next;
    logic req_prev_reg, req_prev_next;
    logic fault_reg, fault_next;
    logic card_clk_reg, card_clk_next;
    logic step_done, req_fall, any_fault, in_session, clk_rise;

    always_comb begin
        step_done = (step_reg == SW'(STEP_CYCLES - 1));
        req_fall = req_prev_reg && !held_reg.power_request_n;
        // removal, either supervisor, heat or over-current
        any_fault = !sync2_reg.presence || sync2_reg.vcc_fault ||
                    sync2_reg.vdd_fault || sync2_reg.over_temp ||
                    sync2_reg.over_current;
        in_session = (seq_reg != SEQ_OFF);
        clk_rise = card_clk_next && !card_clk_reg;
        req_prev_next = held_reg.power_request_n;
        seq_next = seq_reg;
        step_next = step_done ? '0 : step_reg + 1'b1;
        rst_cnt_next = rst_cnt_reg;
        fault_next = fault_reg;
        if (!held_reg.power_request_n == 1'b0) begin
            fault_next = 1'b0;
        end
        case (seq_reg)
            SEQ_OFF: begin
                step_next = '0;
                rst_cnt_next = '0;
                // edge only, and only when awake with a card present
                if (req_fall && awake_reg && !sleep_reg &&
                    sync2_reg.presence) begin
                    seq_next = SEQ_ACT_VCC;
                end
            end
            SEQ_ACT_VCC: if (step_done) seq_next = SEQ_ACT_IO;
            SEQ_ACT_IO: if (step_done) seq_next = SEQ_ACT_CLK;
            SEQ_ACT_CLK: if (step_done) seq_next = SEQ_ON;
            SEQ_ON: step_next = '0;
            SEQ_DEACT_RST: if (step_done) seq_next = SEQ_DEACT_CLK;
            SEQ_DEACT_CLK: if (step_done) seq_next = SEQ_DEACT_IO;
            SEQ_DEACT_IO: if (step_done) seq_next = SEQ_DEACT_VCC;
            SEQ_DEACT_VCC: if (step_done) seq_next = SEQ_OFF;
            default: seq_next = SEQ_OFF;
        endcase
        // reset-hold counter counts card clocks from clock start
        if (clk_rise && rst_cnt_reg != RW'(RST_HOLD_CLKS)) begin
            rst_cnt_next = rst_cnt_reg + 1'b1;
        end
        if (seq_reg inside {SEQ_ACT_VCC, SEQ_ACT_IO, SEQ_ACT_CLK, SEQ_ON})
        begin
            if (any_fault) begin
                fault_next = 1'b1;
                seq_next = SEQ_DEACT_RST;
                step_next = '0;
            end else if (held_reg.power_request_n) begin
                seq_next = SEQ_DEACT_RST;
                step_next = '0;
            end
        end
    end

    // divided clocks from synchronised oscillator edges
    logic osc_prev_reg, osc_prev_next;
    logic div2_reg, div2_next;
    logic div4_reg, div4_next;
    logic osc_rise, clk_on, sel_clk;

    always_comb begin
        osc_prev_next = sync2_reg.osc;
        osc_rise = sync2_reg.osc && !osc_prev_reg;
        div2_next = osc_rise ? !div2_reg : div2_reg;
        div4_next = (osc_rise && !div2_reg) ? !div4_reg : div4_reg;
        case ({held_reg.div_hi, held_reg.div_lo})
            `SCHC_DIV_FULL: sel_clk = sync2_reg.osc;
            `SCHC_DIV_QUARTER: sel_clk = div4_reg;
            default: sel_clk = div2_reg;
        endcase
        // clock runs from its activation step until its stop step
        clk_on = seq_reg inside {SEQ_ACT_CLK, SEQ_ON, SEQ_DEACT_RST};
        if (!clk_on || sleep_reg) begin
            card_clk_next = 1'b0;
        end else if (held_reg.sync_mode) begin
            card_clk_next = sync2_reg.strobe;
        end else begin
            card_clk_next = sel_clk;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            seq_reg <= SEQ_OFF;
            step_reg <= '0;
            rst_cnt_reg <= '0;
            req_prev_reg <= 1'b1;
            fault_reg <= 1'b0;
            card_clk_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
            div2_reg <= 1'b0;
            div4_reg <= 1'b0;
        end else begin
            seq_reg <= seq_next;
            step_reg <= step_next;
            rst_cnt_reg <= rst_cnt_next;
            req_prev_reg <= req_prev_next;
            fault_reg <= fault_next;
            card_clk_reg <= card_clk_next;
            osc_prev_reg <= osc_prev_next;
            div2_reg <= div2_next;
            div4_reg <= div4_next;
        end
    end

    // output stage, all from flops
    logic reception;
    logic [2:0] host_oe_reg, host_oe_next, card_oe_reg, card_oe_next;
    logic [2:0] card_val_reg, card_val_next;
    logic rst_reg, rst_next, status_reg, status_next;
    logic conv_reg, conv_next, osc_buf_reg, osc_buf_next;

    always_comb begin
        reception = sync2_reg.unit_select &&
            (seq_reg inside {SEQ_ACT_IO, SEQ_ACT_CLK, SEQ_ON,
                             SEQ_DEACT_RST, SEQ_DEACT_CLK});
        // open-drain relay; a side never echoes a low it drives itself
        host_oe_next = reception ? (~sync2_reg.card_data & ~card_oe_reg)
                                 : 3'h0;
        card_oe_next = reception ? (~sync2_reg.host_data & ~host_oe_reg)
                                 : 3'h7;
        card_val_next = 3'h0;
        // async mode waits out the hold count before reset may rise
        rst_next = (seq_reg == SEQ_ON) && held_reg.host_reset &&
                   (held_reg.sync_mode ||
                    rst_cnt_reg == RW'(RST_HOLD_CLKS));
        if ((in_session || fault_reg) && !held_reg.power_request_n) begin
            status_next = !fault_reg && !(any_fault && seq_reg != SEQ_OFF
                && seq_reg < SEQ_DEACT_RST);
        end else if (sleep_reg) begin
            status_next = sync2_reg.presence;
        end else begin
            status_next = sync2_reg.presence && awake_reg;
        end
        conv_next = !sleep_reg && seq_reg != SEQ_OFF;
        osc_buf_next = !sleep_reg && sync2_reg.osc;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            host_oe_reg <= 3'h0;
            card_oe_reg <= 3'h7;
            card_val_reg <= 3'h0;
            rst_reg <= 1'b0;
            status_reg <= 1'b0;
            conv_reg <= 1'b0;
            osc_buf_reg <= 1'b0;
        end else begin
            host_oe_reg <= host_oe_next;
            card_oe_reg <= card_oe_next;
            card_val_reg <= card_val_next;
            rst_reg <= rst_next;
            status_reg <= status_next;
            conv_reg <= conv_next;
            osc_buf_reg <= osc_buf_next;
        end
    end

    assign o_host_data = 3'h0;
    assign o_host_data_oe = host_oe_reg;
    assign o_host_weak_pullup = !sync2_reg.unit_select;
    assign o_card_data = card_val_reg;
    assign o_card_data_oe = card_oe_reg;
    assign o_status = status_reg;
    assign o_status_oe = sync2_reg.unit_select;
    assign o_card_clk = card_clk_reg;
    assign o_card_rst = rst_reg;
    assign o_conv_enable = conv_reg;
    assign o_conv_5v_select = held_reg.voltage_select;
    assign o_sleep_state = sleep_reg;
    assign o_osc_buffer_out = osc_buf_reg;
endmodule

// ### verif/schc_props.sv
// Purpose: port assertions for schc_host_control
// Assumes: pin inputs reach the logic through a two-flop synchroniser
// Notes: settle windows allow for that synchroniser latency
module schc_props
    import schc_pkg::*;
(
    input wire logic i_clk, // clock
    input wire logic i_rst_b, // reset
    input wire logic i_unit_select, // select
    input wire logic i_presence_detect, // card in
    input wire logic i_over_current, // fault
    input wire logic i_over_temp, // fault
    input wire logic i_vcc_fault, // fault
    input wire logic i_vdd_fault, // fault
    input wire logic i_osc_input, // osc
    input wire logic [2:0] o_host_data_oe, // host oe
    input wire logic o_host_weak_pullup, // pull-up
    input wire logic [2:0] o_card_data_oe, // card oe
    input wire logic o_status, // status
    input wire logic o_status_oe, // status oe
    input wire logic o_card_clk, // card clock
    input wire logic o_card_rst, // card reset
    input wire logic o_conv_enable, // converter
    input wire logic o_sleep_state, // asleep
    input wire logic o_osc_buffer_out // osc copy
);
    logic any_fault;
    // removal counts as a fault only inside a session
    assign any_fault = i_over_current || i_over_temp || i_vcc_fault ||
        i_vdd_fault || !i_presence_detect;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // card reset high means the session is fully on
    sequence s_fault;
        $rose(any_fault) && o_card_rst && o_conv_enable;
    endsequence
    sequence s_osc_still;
        (!o_sleep_state && $stable(i_osc_input)) [*4];
    endsequence
    property p_deselect;
        (!i_unit_select) [*5] |->
            !o_status_oe && o_host_weak_pullup && o_host_data_oe == 3'h0;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("deselected lines not released");
    property p_osc_copy;
        s_osc_still |-> o_osc_buffer_out == i_osc_input;
    endproperty
    a_osc_copy: assert property (p_osc_copy)
        else $error("oscillator copy differs");
    property p_fault_status;
        s_fault |-> ##[1:6] !o_status;
    endproperty
    a_fault_status: assert property (p_fault_status)
        else $error("status high after a session fault");
    property p_fault_deact;
        s_fault |-> ##[1:6] !o_card_rst ##[1:30] !o_conv_enable;
    endproperty
    a_fault_deact: assert property (p_fault_deact)
        else $error("fault did not deactivate the card");
    property p_sleep_off;
        o_sleep_state [*2] |-> !o_conv_enable && !o_osc_buffer_out &&
            !o_card_clk;
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("activity while asleep");
    property p_wake_block;
        $fell(o_sleep_state) |-> (!o_conv_enable) [*8];
    endproperty
    a_wake_block: assert property (p_wake_block)
        else $error("activation during wake time");
    property p_deact_order;
        $fell(o_conv_enable) |-> !o_card_rst && !o_card_clk &&
            o_card_data_oe == 3'h7;
    endproperty
    a_deact_order: assert property (p_deact_order)
        else $error("supply off before reset, clock and lines");
    property p_no_card;
        (o_status_oe && !i_presence_detect) [*5] |-> !o_status;
    endproperty
    a_no_card: assert property (p_no_card)
        else $error("status high with no card");
endmodule
bind schc_host_control schc_props i_props (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_unit_select(i_unit_select),
    .i_presence_detect(i_presence_detect), .i_over_current(i_over_current),
    .i_over_temp(i_over_temp), .i_vcc_fault(i_vcc_fault),
    .i_vdd_fault(i_vdd_fault), .i_osc_input(i_osc_input),
    .o_host_data_oe(o_host_data_oe), .o_host_weak_pullup(o_host_weak_pullup),
    .o_card_data_oe(o_card_data_oe), .o_status(o_status),
    .o_status_oe(o_status_oe), .o_card_clk(o_card_clk),
    .o_card_rst(o_card_rst), .o_conv_enable(o_conv_enable),
    .o_sleep_state(o_sleep_state), .o_osc_buffer_out(o_osc_buffer_out));

// ### verif/schc_host_model.sv
// Purpose: host side model: clock sources and open-drain host lines
// Assumes: host lines carry pull-ups, parties only pull low
// Notes: sources are offset from i_clk edges so sampling never races
module schc_host_model (
    input wire logic [2:0] i_oe, // device pulls low
    input wire logic [2:0] i_drive, // host level
    output logic [2:0] o_line, // resolved level
    output logic o_osc, // period 400 ns
    output logic o_strobe // period 480 ns
);
    timeunit 1ns;
    timeprecision 1ns;
    // pull-up wins unless a party pulls low
    assign o_line = ~i_oe & i_drive;
    // free running sources, as a crystal and a host timer would be
    initial begin
        o_osc = 1'b0;
        #10;
        forever #200 o_osc = ~o_osc;
    end
    initial begin
        o_strobe = 1'b0;
        #10;
        forever #240 o_strobe = ~o_strobe;
    end
endmodule

// ### verif/tb_top.sv
// Purpose: self-checking bench for schc_host_control
// Assumes: shortened wake, step and reset-hold counts
// Notes: pins change on rising edges, outputs sampled on falling edges
module tb_top
    import schc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WAKE = 20;
    localparam int HOLD = 5;
    logic clk, rst_b, sel, presence_detect, oc, ot, vccf, vddf, osc, strobe, wpu;
    logic status, status_oe, cclk, crst, conv, v5sel, sleep_st, osc_buf;
    logic [2:0] cdata, cline, hdrive, hline, hoe, coe, cdo, hdo;
    schc_ctrl_type ctrl;
    int fail_count, n_checks, per, hi, n, cyc = 0;
    int exp_per [4] = '{20, 10, 40, 20};
    // card line level from the device enable and the card drive
    assign cline = ~coe & cdata;
    schc_host_model i_host (.i_oe(hoe), .i_drive(hdrive), .o_line(hline),
        .o_osc(osc), .o_strobe(strobe));
    schc_host_control #(.WAKE_CYCLES(WAKE), .STEP_CYCLES(3),
        .RST_HOLD_CLKS(HOLD)) i_dut (
        .i_clk(clk), .i_rst_b(rst_b), .i_unit_select(sel),
        .i_card_power_request_n(ctrl.power_request_n),
        .i_card_voltage_select(ctrl.voltage_select),
        .i_host_reset_in(ctrl.host_reset),
        .i_sync_mode_select(ctrl.sync_mode),
        .i_div_select_hi(ctrl.div_hi), .i_div_select_lo(ctrl.div_lo),
        .i_sleep_request(ctrl.sleep_request), .i_presence_detect(presence_detect),
        .i_over_current(oc), .i_over_temp(ot), .i_vcc_fault(vccf),
        .i_vdd_fault(vddf), .i_osc_input(osc), .i_strobe(strobe),
        .i_host_data(hline), .o_host_data(hdo), .o_host_data_oe(hoe),
        .o_host_weak_pullup(wpu), .i_card_data(cline), .o_card_data(cdo),
        .o_card_data_oe(coe), .o_status(status), .o_status_oe(status_oe),
        .o_card_clk(cclk), .o_card_rst(crst), .o_conv_enable(conv),
        .o_conv_5v_select(v5sel), .o_sleep_state(sleep_st),
        .o_osc_buffer_out(osc_buf));
    // 25 MHz system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // a hang is cut short well beyond the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    function automatic logic sig(input int w);
        case (w)
            0: return conv;
            1: return crst;
            2: return status;
            default: return cclk;
        endcase
    endfunction
    // bounded wait, at falling edges, for an output level
    task automatic wait_sig(input int w, input logic v, input int lim);
        @(negedge clk);
        for (int t = 0; t < lim && sig(w) !== v; t++) @(negedge clk);
    endtask
    // card clock period and high time in system clocks
    task automatic measure();
        wait_sig(3, 1'b0, 400);
        wait_sig(3, 1'b1, 400);
        for (hi = 0; hi < 400 && cclk === 1'b1; hi++) @(negedge clk);
        for (per = hi; per < 800 && cclk === 1'b0; per++) @(negedge clk);
    endtask
    // activation needs a fresh high to low edge of the request
    task automatic activate();
        @(posedge clk) ctrl.power_request_n <= 1'b1;
        repeat (6) @(posedge clk);
        ctrl.power_request_n <= 1'b0;
        wait_sig(0, 1'b1, 20);
    endtask
    task automatic deact();
        @(posedge clk) ctrl.power_request_n <= 1'b1;
        wait_sig(0, 1'b0, 60);
        chk({cdo, coe}, 8'h07);
    endtask
    // main sequence
    initial begin
        {rst_b, presence_detect, oc, ot, vccf, vddf} = 6'h00;
        sel = 1'b1;
        cdata = 3'h7;
        hdrive = 3'h7;
        ctrl = 7'h60; // request idle high, 5.0 V, async, half rate
        @(negedge clk);
        chk({conv, wpu, status_oe, coe}, 8'h17);
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (WAKE + 10) @(negedge clk);
        chk(status, 8'h00);
        @(posedge clk) presence_detect <= 1'b1;
        repeat (6) @(negedge clk);
        chk(status, 8'h01);
        @(posedge clk) presence_detect <= 1'b0;
        activate();
        chk(conv, 8'h00);
        @(posedge clk) presence_detect <= 1'b1;
        activate();
        chk({conv, v5sel}, 8'h03);
        // host reset raised early is held back by the sequencer
        @(posedge clk) ctrl.host_reset <= 1'b1;
        n = 0;
        hi = 0;
        for (int t = 0; t < 900 && crst !== 1'b1; t++) begin
            @(negedge clk);
            n += (cclk === 1'b1 && hi == 0) ? 1 : 0;
            hi = (cclk === 1'b1) ? 1 : 0;
        end
        chk(crst, 8'h01);
        chk(8'(n >= HOLD && n <= HOLD + 1), 8'h01);
        // every divider code; the oscillator period is 10 clocks
        for (int c = 0; c < 4; c++) begin
            @(posedge clk) {ctrl.div_hi, ctrl.div_lo} <= 2'(c);
            repeat (40) @(posedge clk);
            measure();
            chk(8'(per), 8'(exp_per[c]));
            chk(8'(hi), 8'(c == 1 ? 5 : exp_per[c] / 2));
        end
        // deselected: controls frozen, host side released
        @(posedge clk) sel <= 1'b0;
        cdata <= 3'h6;
        {ctrl.div_hi, ctrl.div_lo} <= 2'h2;
        repeat (40) @(posedge clk);
        chk({hdo, wpu, status_oe, hoe}, 8'h10);
        measure();
        chk(8'(per), 8'h14);
        @(posedge clk) sel <= 1'b1;
        cdata <= 3'h7;
        repeat (40) @(posedge clk);
        measure();
        chk(8'(per), 8'h28);
        deact();
        // removal and each fault kind inside a live session
        for (int f = 0; f < 5; f++) begin
            @(posedge clk) ctrl.voltage_select <= f[0];
            activate();
            chk(v5sel, 8'(f[0]));
            wait_sig(1, 1'b1, 900);
            @(posedge clk) {vddf, vccf, ot, oc} <= 4'((1 << f) >> 1);
            presence_detect <= (f != 0);
            wait_sig(2, 1'b0, 8);
            chk(status, 8'h00);
            wait_sig(0, 1'b0, 40);
            chk({conv, crst, cclk, status}, 8'h00);
            @(posedge clk) {vddf, vccf, ot, oc} <= 4'h0;
            presence_detect <= 1'b1;
            ctrl.power_request_n <= 1'b1;
            repeat (WAKE + 10) @(posedge clk);
        end
        // synchronous cards take the strobe, period 12 clocks
        @(posedge clk) ctrl.sync_mode <= 1'b1;
        activate();
        repeat (30) @(posedge clk);
        measure();
        chk(8'(per), 8'h0C);
        chk(crst, 8'h01);
        deact();
        // sleep is entered here with the request high
        @(posedge clk) ctrl.sync_mode <= 1'b0;
        ctrl.sleep_request <= 1'b1;
        repeat (6) @(negedge clk);
        chk({sleep_st, osc_buf, conv}, 8'h04);
        @(posedge clk) presence_detect <= 1'b0;
        repeat (6) @(negedge clk);
        chk(status, 8'h00);
        @(posedge clk) presence_detect <= 1'b1;
        repeat (6) @(negedge clk);
        chk(status, 8'h01);
        @(posedge clk) ctrl.power_request_n <= 1'b0;
        repeat (6) @(posedge clk);
        ctrl.sleep_request <= 1'b0;
        repeat (6) @(negedge clk);
        chk(status, 8'h00);
        repeat (WAKE + 4) @(negedge clk);
        chk({status, conv}, 8'h02);
        activate();
        chk(conv, 8'h01);
        deact();
        final_report();
    end
endmodule
